/* src/supply_pulse_programming_logic.sv */
/*
  Programming logic behind the supply pin: classifies filtered level-detector
  outputs into pulses, decodes register and mode keys, runs trial codes,
  addresses and fires fuses, and reads them back.
  Assumes the comparators and the fuse bank are outside; fuse states arrive
  on FUSE_STATE and survive reset, and RST_N is the power-on reset.
  The level inputs are taken as already synchronous to CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Supply excursions are classified as low, mid or high symbols.
// - Trial values live only in flops and are lost on power cycle.
// - Permanent-write mode fires one fuse; the lock is set that way too.
// - Readback mode reports whether each addressed fuse is blown.
// - With lock blown, every register key is refused.
// - Register keys are high, mid, then a register-specific tail.
// - Four virtual trial registers: sign and direction, wrapping magnitude.
// - Eleven mids then a high after a physical register key enter write mode; twelve mids then a high enter read mode.
// - Each trial mid pulse adds one to the code at its falling edge; physical registers stop at their maximum.
// - The trial code drives the applied parameter at once.
// - Supply cycling returns unblown positions to their initial state.
// - Code presets to 1 at the end of a trial register key.
// - Virtual magnitude registers wrap to 0 after the maximum code.
// - Fall slope sits in bits 1:0, inversion in bit 2.
// - A code is the binary value of the fuse pattern, bit 0 first.
// - Blown fuses stay set; trial values only add to them.
// - Every selection starts from the initial state reached at power-up.
// - Write addressing is a one-hot shifter from bit 0, one mid per step.
// - Lock: output register, write key, four mids, then a blow pulse.
// - Magnitude is 8 bits; sign, inversion, lock 1 bit; fall 2 bits.
module supply_pulse_programming_logic #(
  parameter logic [supply_pulse_pkg::WIDTH_W-1:0] BLOW_CYCLES =
    supply_pulse_pkg::FUSE_BLOW_CYCLES,
  parameter logic [supply_pulse_pkg::WIDTH_W-1:0] KEY_CYCLES =
    supply_pulse_pkg::KEY_PULSE_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic LEVEL_MID,
  input wire logic LEVEL_HIGH,
  input wire supply_pulse_pkg::param_t FUSE_STATE,
  output supply_pulse_pkg::param_t PARAMS,
  output logic LOCKED,
  output supply_pulse_pkg::blow_t BLOW,
  output supply_pulse_pkg::read_t READBACK
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-register helpers.
  // Both helpers are pure functions; code_max looks only at the register index, fuse_bits also at the fuses.

  // Largest code each register can hold in trial mode.
  // Virtual registers use the full magnitude range and wrap instead.
  function automatic logic [7:0] code_max(input logic [2:0] sel);
    logic [7:0] m;
    m = supply_pulse_pkg::MAG_MAX;
    if (sel == supply_pulse_pkg::REG_SIGN) begin
      m = supply_pulse_pkg::SIGN_MAX;
    end else if (sel == supply_pulse_pkg::REG_OUTPUT) begin
      m = supply_pulse_pkg::OUTPUT_MAX;
    end
    return m;
  endfunction

  // Fuse pattern of a physical register as a code, bit 0 first.
  // The output register holds slope, inversion and lock; bit 3 is unused.
  function automatic logic [7:0] fuse_bits(input logic [2:0] sel,
                                           input supply_pulse_pkg::param_t f);
    logic [7:0] b;
    b = f.mag;
    if (sel == supply_pulse_pkg::REG_SIGN) begin
      b = {7'h00, f.sign};
    end else if (sel == supply_pulse_pkg::REG_OUTPUT) begin
      b = {3'h0, f.lock, 1'b0, f.inv, f.fall};
    end
    return b;
  endfunction

  // The whole state is one record; the comb block fills a copy and the flop stores it.
  // Keeping it in one place makes the power-on clear a single assignment.
  supply_pulse_pkg::core_t q_reg;
  supply_pulse_pkg::core_t q_next;
  // Working values of the comb block; none of them is stored.
  supply_pulse_pkg::level_t raw_level;
  supply_pulse_pkg::param_t overlay;
  logic fell;
  logic pulse_ok;
  logic sym_high;
  logic virtual_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // One pass computes the filter, pulse measure, key decode and outputs.
  // Symbols are taken on the falling edge of each pulse, after the filter,
  // so the key decode never sees a level that has not settled.
  // The cost is one filter span of latency, far below the shortest gap.
  always_comb begin
    q_next = q_reg;
    overlay = '0;
    // High implies mid at the comparators, so high takes precedence.
    raw_level = LEVEL_HIGH ? supply_pulse_pkg::LVL_HIGH :
                LEVEL_MID ? supply_pulse_pkg::LVL_MID : supply_pulse_pkg::LVL_LOW;

    // A level must stand for the filter span before it is believed.
    // Short spikes from supply noise therefore never reach the decode below.
    if (raw_level == q_reg.lvl) begin
      q_next.fcnt = 4'h0;
    end else if (q_reg.fcnt == supply_pulse_pkg::FILTER_LAST) begin
      q_next.lvl = raw_level;
      q_next.fcnt = 4'h0;
    end else begin
      q_next.fcnt = q_reg.fcnt + 4'h1;
    end

    // Measure each pulse: its width and the highest level it reached.
    // The width saturates rather than wraps, so a very long blow stays long.
    if (q_reg.lvl != supply_pulse_pkg::LVL_LOW) begin
      if (q_reg.width != '1) begin
        q_next.width = q_reg.width + 1'b1;
      end
      if (q_reg.lvl == supply_pulse_pkg::LVL_HIGH) begin
        q_next.peak = 1'b1;
      end
    end
    // The filtered level returns to low in this cycle.
    fell = (q_reg.lvl != supply_pulse_pkg::LVL_LOW) &&
           (q_next.lvl == supply_pulse_pkg::LVL_LOW);
    pulse_ok = q_reg.width >= KEY_CYCLES;
    sym_high = q_reg.peak || (q_reg.lvl == supply_pulse_pkg::LVL_HIGH);
    virtual_reg = q_reg.reg_sel <= supply_pulse_pkg::REG_NEG_DOWN;

    // Every symbol is acted on at the falling edge of its pulse.
    if (fell) begin
      q_next.width = '0;
      q_next.peak = 1'b0;
      if (!pulse_ok) begin
        // Runt pulses are treated as supply noise and abort the key.
        // A device that has just blown stays put, so a power-down ramp cannot restart it.
        if (q_reg.st != supply_pulse_pkg::ST_DONE) begin
          q_next.st = supply_pulse_pkg::ST_INIT;
          q_next.try_on = 1'b0;
        end
      end else begin
        unique case (q_reg.st)
          // Idle: only a high pulse can open a key.
          supply_pulse_pkg::ST_INIT: begin
            if (sym_high) begin
              q_next.st = supply_pulse_pkg::ST_PREFIX;
            end
          end
          // The second symbol of every key must be a mid.
          supply_pulse_pkg::ST_PREFIX: begin
            q_next.mcnt = 4'h0;
            q_next.st = sym_high ? supply_pulse_pkg::ST_INIT :
                        supply_pulse_pkg::ST_SELECT;
          end
          // Mids count the register; the closing high picks it, unless locked.
          // A tail longer than the last register is treated as noise.
          supply_pulse_pkg::ST_SELECT: begin
            if (!sym_high) begin
              if (q_reg.mcnt != 4'hf) begin
                q_next.mcnt = q_reg.mcnt + 4'h1;
              end
            end else if (FUSE_STATE.lock || q_reg.mcnt > 4'(supply_pulse_pkg::REG_LAST)) begin
              q_next.st = supply_pulse_pkg::ST_INIT;
            end else begin
              q_next.reg_sel = q_reg.mcnt[2:0];
              q_next.code = supply_pulse_pkg::CODE_PRESET;
              q_next.try_on = 1'b1;
              q_next.mcnt = 4'h0;
              q_next.st = supply_pulse_pkg::ST_TRY;
            end
          end
          // Mids step the trial code; a high closes a mode key or ends the trial.
          // Mids are counted from the key on, so the mode tail also steps the code.
          supply_pulse_pkg::ST_TRY: begin
            if (!sym_high) begin
              if (q_reg.mcnt != 4'hf) begin
                q_next.mcnt = q_reg.mcnt + 4'h1;
              end
              if (virtual_reg) begin
                q_next.code = q_reg.code + 8'h01;
              end else if (q_reg.code != code_max(q_reg.reg_sel)) begin
                q_next.code = q_reg.code + 8'h01;
              end
            end else begin
              // The mode key shares pulses with trial counting; drop the trial.
              // Virtual registers have no fuses, so a mode key on them is refused.
              q_next.try_on = 1'b0;
              q_next.addr = supply_pulse_pkg::ADDR_INIT;
              if (virtual_reg) begin
                q_next.st = supply_pulse_pkg::ST_INIT;
              end else if (q_reg.mcnt == supply_pulse_pkg::WRITE_KEY_MIDS) begin
                q_next.st = supply_pulse_pkg::ST_WRITE;
              end else if (q_reg.mcnt == supply_pulse_pkg::READ_KEY_MIDS) begin
                q_next.st = supply_pulse_pkg::ST_READ;
              end else begin
                q_next.st = supply_pulse_pkg::ST_INIT;
              end
            end
          end
          // Mids walk the one-hot address; a long high is the fuse blow.
          // Only a blow that lasts the full span ends programming until reset.
          supply_pulse_pkg::ST_WRITE: begin
            if (!sym_high) begin
              q_next.addr = {q_reg.addr[6:0], 1'b0};
            end else if (q_reg.width >= BLOW_CYCLES) begin
              q_next.st = supply_pulse_pkg::ST_DONE;
            end
          end
          // Mids walk the address; each high reports the addressed fuse.
          supply_pulse_pkg::ST_READ: begin
            if (!sym_high) begin
              q_next.addr = {q_reg.addr[6:0], 1'b0};
            end else begin
              q_next.rd.valid = 1'b1;
              q_next.rd.value = |(fuse_bits(q_reg.reg_sel, FUSE_STATE) & q_reg.addr);
            end
          end
          // After a blow everything waits for the supply to be cycled.
          supply_pulse_pkg::ST_DONE: begin
            q_next.st = supply_pulse_pkg::ST_DONE;
          end
          // Unused state code: fall back to idle.
          default: begin
            q_next.st = supply_pulse_pkg::ST_INIT;
          end
        endcase
      end
    end

    // The fuse driver is energised only while high stands in write mode.
    // An address walked past bit 7 selects no fuse, so nothing is driven then.
    q_next.blow.fire = (q_reg.st == supply_pulse_pkg::ST_WRITE) &&
                       (q_next.lvl == supply_pulse_pkg::LVL_HIGH) &&
                       (q_reg.addr != 8'h00) &&
                       !FUSE_STATE.lock;
    q_next.blow.reg_sel = q_reg.reg_sel;
    q_next.blow.addr = q_reg.addr;

    // Map the live trial code onto the fields of the selected register.
    // Down-counting registers apply the inverted code, so code 1 is the top minus one.
    if (q_next.try_on) begin
      unique case (q_next.reg_sel)
        supply_pulse_pkg::REG_POS_UP: overlay.mag = q_next.code;
        supply_pulse_pkg::REG_NEG_UP: begin
          overlay.mag = q_next.code;
          overlay.sign = 1'b1;
        end
        supply_pulse_pkg::REG_POS_DOWN: overlay.mag = ~q_next.code;
        supply_pulse_pkg::REG_NEG_DOWN: begin
          overlay.mag = ~q_next.code;
          overlay.sign = 1'b1;
        end
        supply_pulse_pkg::REG_MAGNITUDE: overlay.mag = q_next.code;
        supply_pulse_pkg::REG_SIGN: overlay.sign = q_next.code[0];
        supply_pulse_pkg::REG_OUTPUT: begin
          overlay.fall = q_next.code[supply_pulse_pkg::FALL_LSB +: 2];
          overlay.inv = q_next.code[supply_pulse_pkg::INV_BIT];
        end
        default: overlay = '0;
      endcase
    end
    // Blown fuses can only be added to, never masked by a trial value.
    q_next.prm = FUSE_STATE | overlay;
    q_next.prm.lock = FUSE_STATE.lock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset is the power-on event, so trial state clears with it.
  // Fuse states live outside this block and survive it.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      q_reg <= supply_pulse_pkg::CORE_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.
  // Trial values reach the pins one clock after the symbol that set them.
  assign PARAMS = q_reg.prm;
  assign LOCKED = q_reg.prm.lock;
  assign BLOW = q_reg.blow;
  assign READBACK = q_reg.rd;

endmodule

`default_nettype wire

/* src/supply_pulse_pkg.sv */
/*
  Shared constants and types for the supply-pulse programming logic: pulse
  timing, key lengths, register indices, field layouts and the state record.
  Assumes a single 100 MHz clock; times are converted to cycles here.
*/
package supply_pulse_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int KEY_PULSE_WIDTH_US = 20;
  localparam int FUSE_BLOW_PULSE_WIDTH_US = 90;
  // Least times round up to whole cycles.
  localparam int KEY_PULSE_CYCLES_INT =
    (KEY_PULSE_WIDTH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FUSE_BLOW_CYCLES_INT =
    (FUSE_BLOW_PULSE_WIDTH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIDTH_W = 14;
  localparam logic [WIDTH_W-1:0] KEY_PULSE_CYCLES = WIDTH_W'(KEY_PULSE_CYCLES_INT);
  localparam logic [WIDTH_W-1:0] FUSE_BLOW_CYCLES = WIDTH_W'(FUSE_BLOW_CYCLES_INT);
  localparam int FILTER_CYCLES = 4;
  localparam logic [3:0] FILTER_LAST = 4'(FILTER_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Keys and registers.
  localparam logic [3:0] WRITE_KEY_MIDS = 4'hb;
  localparam logic [3:0] READ_KEY_MIDS = 4'hc;
  localparam logic [2:0] REG_POS_UP = 3'h0;
  localparam logic [2:0] REG_NEG_UP = 3'h1;
  localparam logic [2:0] REG_POS_DOWN = 3'h2;
  localparam logic [2:0] REG_NEG_DOWN = 3'h3;
  localparam logic [2:0] REG_MAGNITUDE = 3'h4;
  localparam logic [2:0] REG_SIGN = 3'h5;
  localparam logic [2:0] REG_OUTPUT = 3'h6;
  localparam logic [2:0] REG_LAST = 3'h6;
  localparam logic [7:0] CODE_PRESET = 8'h01;
  localparam logic [7:0] ADDR_INIT = 8'h01;
  localparam logic [7:0] SIGN_MAX = 8'h01;
  localparam logic [7:0] OUTPUT_MAX = 8'h07;
  localparam logic [7:0] MAG_MAX = 8'hff;
  // Output register layout: fall slope 1:0, inversion 2, lock 4.
  localparam int FALL_LSB = 0;
  localparam int INV_BIT = 2;
  localparam int LOCK_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    LVL_LOW = 2'b00,
    LVL_MID = 2'b01,
    LVL_HIGH = 2'b10
  } level_t;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_PREFIX = 3'b001,
    ST_SELECT = 3'b010,
    ST_TRY = 3'b011,
    ST_WRITE = 3'b100,
    ST_READ = 3'b101,
    ST_DONE = 3'b110
  } state_t;

  typedef struct packed {
    logic [7:0] mag;
    logic sign;
    logic [1:0] fall;
    logic inv;
    logic lock;
  } param_t;

  typedef struct packed {
    logic fire;
    logic [2:0] reg_sel;
    logic [7:0] addr;
  } blow_t;

  typedef struct packed {
    logic valid;
    logic value;
  } read_t;

  typedef struct packed {
    level_t lvl;
    logic [3:0] fcnt;
    logic [WIDTH_W-1:0] width;
    logic peak;
    state_t st;
    logic [3:0] mcnt;
    logic [2:0] reg_sel;
    logic [7:0] code;
    logic try_on;
    logic [7:0] addr;
    param_t prm;
    blow_t blow;
    read_t rd;
  } core_t;

  localparam core_t CORE_RESET = '{
    lvl: LVL_LOW, fcnt: 4'h0, width: '0, peak: 1'b0, st: ST_INIT,
    mcnt: 4'h0, reg_sel: 3'h0, code: 8'h00, try_on: 1'b0, addr: ADDR_INIT,
    prm: '0, blow: '0, rd: '0};

endpackage

/* testbench/supply_programmer.sv */
/*
  Programmer model: drives the mid and high comparator outputs as a supply would.
  Assumes the bench clock; levels change only at its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module supply_programmer #(parameter int W = 60) (
  input wire logic clock,
  output var logic level_mid,
  output var logic level_high
);
  // One excursion then a low gap; a high supply also trips the mid comparator.
  task automatic pulse(input logic hi, input int len);
    @(negedge clock);
    level_high = hi;
    level_mid = 1'b1;
    repeat (len) @(negedge clock);
    level_high = 1'b0;
    level_mid = 1'b0;
    repeat (W) @(negedge clock);
  endtask
  // A train of mid pulses.
  task automatic mids(input int n);
    repeat (n) pulse(1'b0, W);
  endtask
  // Register key: high, mid, k more mids, high.
  task automatic key(input int k);
    pulse(1'b1, W);
    mids(k + 1);
    pulse(1'b1, W);
  endtask
  // Mode tail: eleven mids for write, twelve for read, then a high.
  task automatic mode(input int n);
    mids(n);
    pulse(1'b1, W);
  endtask
  // Supply idles at the low level.
  initial begin
    level_mid = 1'b0;
    level_high = 1'b0;
  end
endmodule
`default_nettype wire

/* testbench/prog_checker.sv */
/*
  Assertions on the ports of the supply-pulse programming logic.
  Assumes one clock and a synchronous active-low reset; bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module prog_checker (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic LEVEL_MID,
  input wire logic LEVEL_HIGH,
  input wire supply_pulse_pkg::param_t FUSE_STATE,
  input wire supply_pulse_pkg::param_t PARAMS,
  input wire logic LOCKED,
  input wire supply_pulse_pkg::blow_t BLOW,
  input wire supply_pulse_pkg::read_t READBACK
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Eight quiet cycles leave no symbol in flight through the filter.
  sequence quiet_s;
    (!LEVEL_MID && !LEVEL_HIGH && $stable(FUSE_STATE)) [*8];
  endsequence
  ////////////////////
  blow_one_hot_a: assert property (BLOW.fire |-> $onehot(BLOW.addr))
    else $error("fire without one addressed fuse");
  addr_hot_a: assert property ($onehot0(BLOW.addr))
    else $error("fuse address not one-hot");
  lock_follow_a: assert property ($past(RST_N) |-> LOCKED == $past(FUSE_STATE.lock))
    else $error("lock flag does not follow the lock fuse");
  fuse_kept_a: assert property ($past(RST_N, 2) && $past(RST_N) &&
    FUSE_STATE == $past(FUSE_STATE, 2) |-> (PARAMS & FUSE_STATE) == FUSE_STATE)
    else $error("blown fuse bit not applied");
  fire_rise_a: assert property ($rose(BLOW.fire) |-> LEVEL_HIGH && $past(LEVEL_HIGH, 3))
    else $error("fire without a high level");
  fire_drop_a: assert property ($fell(LEVEL_HIGH) |-> ##[1:8] !BLOW.fire)
    else $error("fire outlasts the high level");
  lock_no_fire_a: assert property (LOCKED |-> !BLOW.fire)
    else $error("fire while locked");
  read_hold_a: assert property (quiet_s |=> $stable(READBACK))
    else $error("readback moved on a quiet supply");
  params_hold_a: assert property (quiet_s |=> $stable(PARAMS))
    else $error("parameters moved on a quiet supply");
  // Main scenarios reached.
  cover property ($rose(BLOW.fire));
  cover property ($rose(READBACK.valid));
  cover property ($rose(LOCKED));
endmodule
bind supply_pulse_programming_logic prog_checker chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .LEVEL_MID(LEVEL_MID), .LEVEL_HIGH(LEVEL_HIGH), .FUSE_STATE(FUSE_STATE),
  .PARAMS(PARAMS), .LOCKED(LOCKED), .BLOW(BLOW), .READBACK(READBACK));
`default_nettype wire

/* testbench/tb_top.sv */
/*
  Self-checking bench for the supply-pulse programming logic.
  Assumes the programmer model; the bench itself plays the fuse bank.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int KEYC = 50;
  localparam int BLOWC = 300;
  logic clock;
  logic rst_n;
  supply_pulse_pkg::param_t fuse_img;
  supply_pulse_pkg::param_t blown = '0;
  wire supply_pulse_pkg::param_t fuse;
  int blow_len = 0;
  supply_pulse_pkg::param_t params;
  supply_pulse_pkg::blow_t blow;
  supply_pulse_pkg::read_t rb;
  logic locked;
  wire logic mid;
  wire logic high;
  int fails = 0;
  int num_checks = 0;
  // Short counts keep the run brief; the key width stays below the blow width.
  supply_pulse_programming_logic #(.BLOW_CYCLES(14'(BLOWC)), .KEY_CYCLES(14'(KEYC))) DUT (
    .CLOCK(clock), .RST_N(rst_n), .LEVEL_MID(mid), .LEVEL_HIGH(high),
    .FUSE_STATE(fuse), .PARAMS(params), .LOCKED(locked), .BLOW(blow), .READBACK(rb));
  supply_programmer #(.W(60)) prog (.clock(clock), .level_mid(mid), .level_high(high));
  // The bench is the fuse bank: a preset image plus whatever the block has blown.
  assign fuse = fuse_img | blown;
  // 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ////////////////////
  // Compare and count.
  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Fuse addressed by a register index and a one-hot field address.
  function automatic supply_pulse_pkg::param_t fuse_hit(input logic [2:0] sel,
                                                        input logic [7:0] a);
    supply_pulse_pkg::param_t h;
    h = '0;
    if (sel == supply_pulse_pkg::REG_MAGNITUDE) begin
      h.mag = a;
    end else if (sel == supply_pulse_pkg::REG_SIGN) begin
      h.sign = a[0];
    end else if (sel == supply_pulse_pkg::REG_OUTPUT) begin
      h.fall = a[1:0];
      h.inv = a[2];
      h.lock = a[4];
    end
    return h;
  endfunction
  // A fire that stood for the blow span sets its fuse for good when it ends.
  always @(posedge clock) begin
    if (blow.fire === 1'b1) begin
      blow_len <= blow_len + 1;
    end else begin
      blow_len <= 0;
      if (blow_len >= BLOWC) begin
        blown <= blown | fuse_hit(blow.reg_sel, blow.addr);
      end
    end
  end
  // Supply cycle with a new fuse image; reset held for eight clocks.
  task automatic cycle_supply(input logic [12:0] f);
    @(negedge clock);
    rst_n = 1'b0;
    fuse_img = f;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
  endtask
  // A bad key falls back; then an up-counting register runs through its wrap.
  task automatic t_wrap;
    cycle_supply(13'h0000);
    prog.key(7);
    check("bad key", params, 13'h0000);
    prog.key(0);
    check("mag preset", {5'h00, params.mag}, 13'h0001);
    prog.mids(254);
    check("mag top", {5'h00, params.mag}, 13'h00ff);
    prog.mids(1);
    check("mag wrap", {5'h00, params.mag}, 13'h0000);
    $display("wrap test done");
  endtask
  // Down-counting register applies the inverted code.
  task automatic t_down;
    cycle_supply(13'h0000);
    prog.key(2);
    check("down preset", {5'h00, params.mag}, 13'h00fe);
    prog.mids(1);
    check("down step", {5'h00, params.mag}, 13'h00fd);
    $display("down test done");
  endtask
  // Shared slope and inversion register, saturation, then loss on supply cycle.
  task automatic t_out;
    cycle_supply(13'h0000);
    prog.key(6);
    check("out preset", {10'h000, params.fall, params.inv}, 13'h0002);
    prog.mids(6);
    check("out code 7", {10'h000, params.fall, params.inv}, 13'h0007);
    prog.mids(1);
    check("out hold", {10'h000, params.fall, params.inv}, 13'h0007);
    cycle_supply(13'h0000);
    check("trial lost", params, 13'h0000);
    $display("output test done");
  endtask
  // Magnitude fuses hold 5: trial adds to them, read mode reports bits 0 and 1.
  task automatic t_read;
    cycle_supply(13'h00a0);
    prog.key(4);
    check("try over fuses", {5'h00, params.mag}, 13'h0005);
    prog.mode(12);
    prog.pulse(1'b1, 60);
    check("read bit0", {11'h000, rb}, 13'h0003);
    prog.mids(1);
    prog.pulse(1'b1, 60);
    check("read bit1", {11'h000, rb}, 13'h0002);
    $display("read test done");
  endtask
  // Lock fuse blown, then the output register key is refused.
  task automatic t_lock;
    cycle_supply(13'h0000);
    prog.key(6);
    prog.mode(11);
    prog.mids(4);
    check("blow addr", {2'h0, blow.reg_sel, blow.addr}, 13'h0610);
    fork
      prog.pulse(1'b1, BLOWC + 20);
      begin
        repeat (100) @(negedge clock);
        check("fire", {12'h000, blow.fire}, 13'h0001);
      end
    join
    check("fire off", {12'h000, blow.fire}, 13'h0000);
    check("lock blown", {12'h000, locked}, 13'h0001);
    cycle_supply(13'h0000);
    check("locked", {12'h000, locked}, 13'h0001);
    prog.key(6);
    check("locked key", params, 13'h0001);
    $display("lock test done");
  endtask
  // Verdict.
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    fuse_img = '0;
    t_wrap;
    t_down;
    t_out;
    t_read;
    t_lock;
    close_out;
  end
  // Watchdog: the tests need about 40k clocks.
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    close_out;
  end
endmodule
`default_nettype wire
